/* File: verification/ssc_host.sv */
// Host model that frames register reads and writes on the block's serial port.
// Assumes the bench resolves the shared data wire from the device's output enable.
`timescale 1ns/1ps
module ssc_host (
  // Clock.
  input  wire logic core_clk_in,
  // Serial port.
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdio_out,
  input  wire logic sdio_in
);

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdio_out = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : hold

  ////////////////////////////////////////////////////////////////////////////
  // One frame: read flag, address, one data byte. Each clock level lasts at least two cycles.
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {rd, 2'b00, addr, wdata};
    rdata = 8'h00;
    @(negedge core_clk_in);
    cs_n_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // While the device owns the wire the host toggles, so a stale level never reads back.
      if (rd && i < 8) sdio_out = ~sdio_out;
      else sdio_out = frame[i];
      hold(3);
      if (i < 8) rdata[i] = sdio_in;
      sclk_out = 1'b1;
      hold(2);
      sclk_out = 1'b0;
    end
    hold(3);
    cs_n_out = 1'b1;
    hold(2);
  endtask : xfer

endmodule : ssc_host

/* File: verification/testbench.sv */
// Self-checking bench for the serial stream channel control block.
// Assumes the host model drives the serial port and the bench drives samples.
`timescale 1ns/1ps
`define CHK(got, exp) check(16'(got), 16'(exp))
module testbench;

  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic        sclk, cs_n, host_sdio, dut_sdio, sdio_oe, sdio_wire;
  logic [13:0] sample_in;
  logic        sample_valid, sample_ready, serial_data, frame, low_rate, pdwn;
  logic [15:0] pat1, pat2;
  int          err_total, num_checks;

  always #2 core_clk_in = ~core_clk_in;
  assign sdio_wire = sdio_oe ? dut_sdio : host_sdio;

  ssc_host host_u (.core_clk_in(core_clk_in), .sclk_out(sclk), .cs_n_out(cs_n),
                   .sdio_out(host_sdio), .sdio_in(sdio_wire));

  ssc_top dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_sdio_in(sdio_wire), .spi_sdio_out(dut_sdio),
    .spi_sdio_oe_out(sdio_oe), .sample_in(sample_in), .sample_valid_in(sample_valid),
    .sample_ready_out(sample_ready), .serial_data_out(serial_data), .frame_out(frame),
    .low_rate_mode_out(low_rate), .power_down_out(pdwn),
    .user_pattern_one_out(pat1), .user_pattern_two_out(pat2));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] b;
    host_u.xfer(1'b0, a, d, b);
  endtask : wr

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] b;
    host_u.xfer(1'b1, a, 8'h00, b);
    `CHK(b, exp);
  endtask : rd_chk

  function automatic int nbits(input logic [2:0] res);
    case (res)
      ssc_pkg::RES_8:  return 8;
      ssc_pkg::RES_10: return 10;
      ssc_pkg::RES_12: return 12;
      default:         return 14;
    endcase
  endfunction : nbits

  // Bits in the order they should appear on the wire, last bit in position 0.
  function automatic logic [13:0] exp_word(input logic [13:0] s, input logic [2:0] res,
                                           input logic lsb);
    int          n;
    logic [13:0] w;
    n = nbits(res);
    w = 14'h0000;
    for (int i = 0; i < n; i++) w = {w[12:0], lsb ? s[14-n+i] : s[13-i]};
    return w;
  endfunction : exp_word

  task automatic push(input logic [13:0] d);
    int cnt;
    cnt = 0;
    @(negedge core_clk_in);
    while (sample_ready !== 1'b1 && cnt < 50) begin
      cnt++;
      @(negedge core_clk_in);
    end
    sample_valid = 1'b1;
    sample_in    = d;
    @(negedge core_clk_in);
    sample_valid = 1'b0;
  endtask : push

  task automatic get_word(input int n, output logic [13:0] w, output int waited);
    waited = 0;
    w      = 14'h0000;
    @(negedge core_clk_in);
    while (frame !== 1'b1 && waited < 200) begin
      waited++;
      @(negedge core_clk_in);
    end
    if (waited < 200) begin
      for (int i = 0; i < n; i++) begin
        w = {w[12:0], serial_data};
        if (i < n - 1) @(negedge core_clk_in);
      end
    end
  endtask : get_word

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [12:0] REGS [6] = '{ssc_pkg::PAT1_LO_ADDR, ssc_pkg::PAT1_HI_ADDR,
    ssc_pkg::PAT2_LO_ADDR, ssc_pkg::PAT2_HI_ADDR, ssc_pkg::STREAM_ADDR, ssc_pkg::CHAN_ADDR};

  initial begin
    logic [7:0]  pb [4];
    logic [7:0]  ctl;
    logic [13:0] d, w;
    logic [13:0] q [$];
    int          wt;
    sample_in    = 14'h0000;
    sample_valid = 1'b0;
    err_total    = 0;
    num_checks   = 0;
    void'($urandom(32'h69df5ee1));
    repeat (2) @(negedge core_clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(REGS[i], 8'h00);
    `CHK(pat1, 16'h0000);
    `CHK(pat2, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      pb[i] = 8'($urandom);
      wr(REGS[i], pb[i]);
    end
    for (int i = 0; i < 4; i++) rd_chk(REGS[i], pb[i]);
    `CHK(pat1, {pb[1], pb[0]});
    `CHK(pat2, {pb[3], pb[2]});
    // Undefined bits read as zero and unmapped places stay empty.
    wr(ssc_pkg::STREAM_ADDR, 8'hFF);
    rd_chk(ssc_pkg::STREAM_ADDR, 8'h8F);
    wr(ssc_pkg::CHAN_ADDR, 8'hFC);
    rd_chk(ssc_pkg::CHAN_ADDR, 8'h00);
    `CHK(pdwn, 1'b0);
    wr(13'h0020, 8'h5A);
    rd_chk(13'h0020, 8'h00);
    // Every resolution code with both bit orders.
    for (int m = 0; m < 16; m++) begin
      ctl = {m[3], 3'b000, m[0], m[2:0]};
      wr(ssc_pkg::STREAM_ADDR, ctl);
      `CHK(low_rate, ctl[3]);
      d = 14'($urandom);
      push(d);
      get_word(nbits(ctl[2:0]), w, wt);
      `CHK(w, exp_word(d, ctl[2:0], ctl[7]));
    end
    // Output reset holds the stream, so the buffer fills until it refuses.
    wr(ssc_pkg::STREAM_ADDR, 8'h02);
    wr(ssc_pkg::CHAN_ADDR, 8'h02);
    for (int i = 0; i < 6; i++) begin
      @(negedge core_clk_in);
      d            = 14'($urandom);
      sample_in    = d;
      sample_valid = 1'b1;
      if (sample_ready === 1'b1) q.push_back(d);
      `CHK(frame, 1'b0);
    end
    @(negedge core_clk_in);
    sample_valid = 1'b0;
    `CHK(q.size(), ssc_pkg::FIFO_DEPTH);
    fork
      wr(ssc_pkg::CHAN_ADDR, 8'h00);
      for (int i = 0; i < 4; i++) begin
        get_word(10, w, wt);
        `CHK(w, exp_word(q[i], ssc_pkg::RES_10, 1'b0));
        if (i > 0) `CHK(wt, 0);
      end
    join
    // Power-down keeps the word waiting until the channel comes back.
    wr(ssc_pkg::CHAN_ADDR, 8'h01);
    `CHK(pdwn, 1'b1);
    d = 14'($urandom);
    push(d);
    get_word(10, w, wt);
    `CHK(wt, 200);
    fork
      wr(ssc_pkg::CHAN_ADDR, 8'h00);
      get_word(10, w, wt);
    join
    `CHK(w, exp_word(d, ssc_pkg::RES_10, 1'b0));
    `CHK(pdwn, 1'b0);
    print_verdict();
  end

  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

endmodule : testbench

/* File: verilog/ssc_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/1ps
module ssc_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  // Filling side.
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // Draining side.
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      count        <= '0;
      in_ready_out <= 1'b1;
    end else begin
      count        <= next_count;
      in_ready_out <= (next_count != CW'(DEPTH));
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

endmodule : ssc_fifo

/* File: verilog/ssc_pkg.sv */
// Constants and carrier types for the serial stream channel control block.
// Assumes a single core clock and a synchronous, active-high reset.
package ssc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port framing.
  localparam int          ADDR_W     = 13;
  localparam int          INSTR_BITS = 16;
  localparam int          FRAME_BITS = 24;
  localparam logic [4:0]  INSTR_LAST = 5'h0F;
  localparam logic [4:0]  FRAME_LAST = 5'h17;
  localparam int          READ_BIT   = 15;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [12:0] PAT1_LO_ADDR = 13'h0019;
  localparam logic [12:0] PAT1_HI_ADDR = 13'h001A;
  localparam logic [12:0] PAT2_LO_ADDR = 13'h001B;
  localparam logic [12:0] PAT2_HI_ADDR = 13'h001C;
  localparam logic [12:0] STREAM_ADDR  = 13'h0021;
  localparam logic [12:0] CHAN_ADDR    = 13'h0022;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values.
  localparam int         LSB_FIRST_POS = 7;
  localparam int         LOW_RATE_POS  = 3;
  localparam int         RES_POS       = 0;
  localparam int         OUT_RST_POS   = 1;
  localparam int         PDWN_POS      = 0;
  localparam logic [7:0] PAT_RESET     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Output word resolution.
  localparam int         WORD_W    = 14;
  localparam logic [2:0] RES_8     = 3'h1;
  localparam logic [2:0] RES_10    = 3'h2;
  localparam logic [2:0] RES_12    = 3'h3;
  localparam logic [2:0] RES_14    = 3'h4;
  localparam logic [3:0] BITS_8    = 4'h8;
  localparam logic [3:0] BITS_10   = 4'hA;
  localparam logic [3:0] BITS_12   = 4'hC;
  localparam logic [3:0] BITS_14   = 4'hE;
  localparam int         FIFO_DEPTH = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic       lsb_first;
    logic       low_rate;
    logic [2:0] res;
  } ssc_stream_ctrl_t;

  typedef struct packed {
    logic out_reset;
    logic power_down;
  } ssc_chan_ctrl_t;

  localparam ssc_stream_ctrl_t STREAM_RESET = '{lsb_first: 1'b0, low_rate: 1'b0, res: 3'h0};
  localparam ssc_chan_ctrl_t   CHAN_RESET   = '{out_reset: 1'b0, power_down: 1'b0};

endpackage : ssc_pkg

/* File: verilog/ssc_top.sv */
// Serial port register bank and one channel's serialized output path.
// Assumes serial port pins and samples are synchronous to core_clk_in.
//
// What this block does
// - Holds a second 16-bit user pattern in a low and a high byte register, both zero at reset.
// - A global bit-order bit sends serial words LSB first when one and MSB first when zero.
// - A global low encode rate bit, zero at reset, enables the mode for rates under 10 MSPS.
// - A resolution field cuts words to 8, 10, 12 or 14 bits, and zero keeps the native word.
// - A channel output reset bit holds this channel's output in reset while one.
// - A channel power-down bit powers down only this channel section while one.
// - Holds a first 16-bit user pattern in a low and a high byte register, both zero at reset.
`timescale 1ns/1ps
module ssc_top (
  // Clock and reset.
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Serial port.
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_sdio_in,
  output logic             spi_sdio_out,
  output logic             spi_sdio_oe_out,
  // Converter samples.
  input  wire logic [13:0] sample_in,
  input  wire logic        sample_valid_in,
  output logic             sample_ready_out,
  // Serialized output and channel state.
  output logic             serial_data_out,
  output logic             frame_out,
  output logic             low_rate_mode_out,
  output logic             power_down_out,
  output logic [15:0]      user_pattern_one_out,
  output logic [15:0]      user_pattern_two_out
);

  typedef enum logic [1:0] {SPI_IDLE, SPI_INSTR, SPI_DATA, SPI_DONE} ssc_spi_state_t;

  ssc_spi_state_t            spi_state;
  logic [4:0]                bit_cnt;
  logic [15:0]               shift;
  logic [15:0]               next_instr;
  logic [15:0]               instr;
  logic [7:0]                rd_shift;
  logic                      sclk_q;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      wr_en;
  logic [12:0]               wr_addr;
  logic [7:0]                wr_data;
  logic [7:0]                pat1_lo;
  logic [7:0]                pat1_hi;
  logic [7:0]                pat2_lo;
  logic [7:0]                pat2_hi;
  ssc_pkg::ssc_stream_ctrl_t stream_ctrl;
  ssc_pkg::ssc_chan_ctrl_t   chan_ctrl;
  logic [13:0]               fifo_data;
  logic                      fifo_valid;
  logic                      pop;
  logic                      busy;
  logic [3:0]                bits_left;
  logic [13:0]               ser_shift;
  logic [13:0]               next_word;
  logic                      enabled;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.
  function automatic logic [3:0] res_bits(input logic [2:0] code);
    case (code)
      ssc_pkg::RES_8:  res_bits = ssc_pkg::BITS_8;
      ssc_pkg::RES_10: res_bits = ssc_pkg::BITS_10;
      ssc_pkg::RES_12: res_bits = ssc_pkg::BITS_12;
      ssc_pkg::RES_14: res_bits = ssc_pkg::BITS_14;
      default:         res_bits = ssc_pkg::BITS_14;
    endcase
  endfunction : res_bits

  // Places the first bit to send at the top of the word.
  function automatic logic [13:0] justify(input logic [13:0] w, input logic lsb,
                                          input logic [3:0] n);
    logic [13:0] r;
    logic [13:0] o;
    r = w >> (ssc_pkg::BITS_14 - n);
    o = w;
    if (lsb) begin
      for (int i = 0; i < ssc_pkg::WORD_W; i++) begin
        o[ssc_pkg::WORD_W-1-i] = r[i];
      end
    end
    justify = o;
  endfunction : justify

  function automatic logic [7:0] reg_read(input logic [12:0] addr);
    case (addr)
      ssc_pkg::PAT1_LO_ADDR: reg_read = pat1_lo;
      ssc_pkg::PAT1_HI_ADDR: reg_read = pat1_hi;
      ssc_pkg::PAT2_LO_ADDR: reg_read = pat2_lo;
      ssc_pkg::PAT2_HI_ADDR: reg_read = pat2_hi;
      ssc_pkg::STREAM_ADDR:  reg_read = {stream_ctrl.lsb_first, 3'h0,
                                         stream_ctrl.low_rate, stream_ctrl.res};
      ssc_pkg::CHAN_ADDR:    reg_read = {6'h00, chan_ctrl.out_reset,
                                         chan_ctrl.power_down};
      default:               reg_read = 8'h00;
    endcase
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  // Serial port: 16-bit instruction, then one data byte.
  assign sclk_rise  = spi_sclk_in && !sclk_q;
  assign sclk_fall  = !spi_sclk_in && sclk_q;
  assign next_instr = {shift[14:0], spi_sdio_in};
  assign wr_addr    = instr[ssc_pkg::ADDR_W-1:0];
  assign wr_data    = {shift[6:0], spi_sdio_in};
  assign wr_en      = !spi_cs_n_in && sclk_rise && (spi_state == SPI_DATA)
                      && (bit_cnt == ssc_pkg::FRAME_LAST) && !instr[ssc_pkg::READ_BIT];

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in || spi_cs_n_in) begin
      spi_state <= SPI_IDLE;
      bit_cnt   <= 5'h00;
      shift     <= 16'h0000;
      instr     <= 16'h0000;
    end else if (sclk_rise) begin
      case (spi_state)
        SPI_IDLE, SPI_INSTR: begin
          shift   <= next_instr;
          bit_cnt <= bit_cnt + 5'h01;
          spi_state <= SPI_INSTR;
          if (bit_cnt == ssc_pkg::INSTR_LAST) begin
            instr     <= next_instr;
            spi_state <= SPI_DATA;
          end
        end
        SPI_DATA: begin
          shift   <= next_instr;
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == ssc_pkg::FRAME_LAST) begin
            spi_state <= SPI_DONE;
          end
        end
        SPI_DONE: begin
          spi_state <= SPI_DONE;
        end
        default: begin
          spi_state <= SPI_IDLE;
        end
      endcase
    end
  end

  // Read data changes on falling edges so the host samples it on rising ones.
  always_ff @(posedge core_clk_in) begin
    if (rst_in || spi_cs_n_in) begin
      rd_shift        <= 8'h00;
      spi_sdio_out    <= 1'b0;
      spi_sdio_oe_out <= 1'b0;
    end else if (sclk_rise && (spi_state != SPI_DATA) && (spi_state != SPI_DONE)
                 && (bit_cnt == ssc_pkg::INSTR_LAST)) begin
      rd_shift <= reg_read(next_instr[ssc_pkg::ADDR_W-1:0]);
    end else if (sclk_fall && (spi_state == SPI_DATA) && instr[ssc_pkg::READ_BIT]) begin
      spi_sdio_out    <= rd_shift[7];
      spi_sdio_oe_out <= 1'b1;
      rd_shift        <= {rd_shift[6:0], 1'b0};
    end else if (sclk_fall && (spi_state == SPI_DONE)) begin
      spi_sdio_out    <= 1'b0;
      spi_sdio_oe_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pat1_lo <= ssc_pkg::PAT_RESET;
      pat1_hi <= ssc_pkg::PAT_RESET;
      pat2_lo <= ssc_pkg::PAT_RESET;
      pat2_hi <= ssc_pkg::PAT_RESET;
    end else if (wr_en) begin
      case (wr_addr)
        ssc_pkg::PAT1_LO_ADDR: pat1_lo <= wr_data;
        ssc_pkg::PAT1_HI_ADDR: pat1_hi <= wr_data;
        ssc_pkg::PAT2_LO_ADDR: pat2_lo <= wr_data;
        ssc_pkg::PAT2_HI_ADDR: pat2_hi <= wr_data;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      stream_ctrl <= ssc_pkg::STREAM_RESET;
      chan_ctrl   <= ssc_pkg::CHAN_RESET;
    end else if (wr_en && (wr_addr == ssc_pkg::STREAM_ADDR)) begin
      stream_ctrl.lsb_first <= wr_data[ssc_pkg::LSB_FIRST_POS];
      stream_ctrl.low_rate  <= wr_data[ssc_pkg::LOW_RATE_POS];
      stream_ctrl.res       <= wr_data[ssc_pkg::RES_POS +: 3];
    end else if (wr_en && (wr_addr == ssc_pkg::CHAN_ADDR)) begin
      chan_ctrl.out_reset  <= wr_data[ssc_pkg::OUT_RST_POS];
      chan_ctrl.power_down <= wr_data[ssc_pkg::PDWN_POS];
    end
  end

  assign user_pattern_one_out = {pat1_hi, pat1_lo};
  assign user_pattern_two_out = {pat2_hi, pat2_lo};
  assign low_rate_mode_out    = stream_ctrl.low_rate;
  assign power_down_out       = chan_ctrl.power_down;

  ////////////////////////////////////////////////////////////////////////////
  // Sample buffer and serializer.
  ssc_fifo #(
    .WIDTH (ssc_pkg::WORD_W),
    .DEPTH (ssc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .in_data_in    (sample_in),
    .in_valid_in   (sample_valid_in),
    .in_ready_out  (sample_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (pop)
  );

  // A powered-down channel stops draining, so back-pressure reaches the source.
  assign enabled   = !chan_ctrl.out_reset && !chan_ctrl.power_down;
  assign pop       = enabled && fifo_valid && (!busy || (bits_left == 4'h0));
  assign next_word = justify(fifo_data, stream_ctrl.lsb_first, res_bits(stream_ctrl.res));

  always_ff @(posedge core_clk_in) begin
    if (rst_in || !enabled) begin
      busy            <= 1'b0;
      bits_left       <= 4'h0;
      ser_shift       <= 14'h0000;
      serial_data_out <= 1'b0;
      frame_out       <= 1'b0;
    end else if (pop) begin
      busy            <= 1'b1;
      bits_left       <= res_bits(stream_ctrl.res) - 4'h1;
      ser_shift       <= {next_word[12:0], 1'b0};
      serial_data_out <= next_word[13];
      frame_out       <= 1'b1;
    end else if (busy && (bits_left != 4'h0)) begin
      bits_left       <= bits_left - 4'h1;
      ser_shift       <= {ser_shift[12:0], 1'b0};
      serial_data_out <= ser_shift[13];
      frame_out       <= 1'b0;
    end else begin
      busy            <= 1'b0;
      serial_data_out <= 1'b0;
      frame_out       <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  pat_two_reset_a: assert property (@(posedge core_clk_in)
    rst_in |=> (user_pattern_two_out == 16'h0000))
    else $error("second pattern not cleared by reset");

  pat_one_reset_a: assert property (@(posedge core_clk_in)
    rst_in |=> (user_pattern_one_out == 16'h0000))
    else $error("first pattern not cleared by reset");

  msb_first_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (pop && !stream_ctrl.lsb_first) |=> (serial_data_out == $past(fifo_data[13])))
    else $error("msb-first word did not start with bit 13");

  lsb_first_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (pop && stream_ctrl.lsb_first && (stream_ctrl.res == ssc_pkg::RES_8))
    |=> (serial_data_out == $past(fifo_data[6])))
    else $error("lsb-first 8-bit word did not start with bit 6");

  low_rate_wr_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (wr_en && (wr_addr == ssc_pkg::STREAM_ADDR)) |=> (low_rate_mode_out == $past(wr_data[3])))
    else $error("low encode rate bit not taken from write");

  res_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (pop && (stream_ctrl.res == ssc_pkg::RES_10))
    |=> (bits_left == (ssc_pkg::BITS_10 - 4'h1)) && busy)
    else $error("10-bit word length wrong");

  chan_reset_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    chan_ctrl.out_reset |=> (!serial_data_out && !frame_out && !busy))
    else $error("output not held in reset");

  pdwn_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    chan_ctrl.power_down |-> (!pop ##1 (!serial_data_out && !frame_out)))
    else $error("powered-down channel still active");

  // Watches the byte actually loaded for a read, not the decode on its own.
  undef_bits_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (sclk_rise && !spi_cs_n_in && (spi_state == SPI_INSTR)
     && (bit_cnt == ssc_pkg::INSTR_LAST)
     && (next_instr[ssc_pkg::ADDR_W-1:0] == ssc_pkg::CHAN_ADDR))
    |=> (rd_shift[7:2] == 6'h00))
    else $error("undefined channel bits read nonzero");

  read_cov_c: cover property (@(posedge core_clk_in)
    spi_sdio_oe_out && instr[ssc_pkg::READ_BIT]);
  lsb_frame_c: cover property (@(posedge core_clk_in)
    pop && stream_ctrl.lsb_first);
  fifo_full_c: cover property (@(posedge core_clk_in)
    !sample_ready_out && chan_ctrl.out_reset);
  pdwn_wait_c: cover property (@(posedge core_clk_in)
    fifo_valid && chan_ctrl.power_down);

endmodule : ssc_top
